//--- rlb_pkg.sv
// Function
// R1 - Loopback switches of both transceivers are set only by serially loading two chained 8-bit shift registers.
// R2 - First register Q5 high with Q4 low sends transceiver 1 tx path 1 to its connector, the reverse to receiver 1.
// R3 - First register Q7 high with Q6 low sends transceiver 1 tx path 2 to its connector, the reverse to receiver 2.
// R4 - First register Q2 high turns on the shunt of transceiver 1 path 1 and Q0 that of path 2; low turns it off.
// R5 - First register Q3 sets path 1 attenuation and Q1 path 2, high meaning -40 dB and low -25 dB.
// R6 - Second register Q2 high with Q3 low sends transceiver 2 tx path 1 to its connector, the reverse to receiver 1.
// R7 - Second register Q0 high with Q1 low sends transceiver 2 tx path 2 to its connector, the reverse to receiver 2.
// R8 - Second register Q5 high turns on the shunt of transceiver 2 path 1 and Q7 that of path 2; low turns it off.
// R9 - Second register Q6 sets path 1 attenuation and Q4 path 2, high meaning -40 dB and low -25 dB.
// R10 - All sixteen bits are shifted on successive clock edges and then one latch pulse updates every output at once.
// R11 - The polarity of each attenuation bit is a build-time parameter defaulting to high meaning -40 dB.
package rlb_pkg;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  // Control register field positions
  localparam int CTRL_CONN_LSB  = 0;   // Four route bits, 1 = to connector
  localparam int CTRL_SHUNT_LSB = 4;   // Four shunt enables
  localparam int CTRL_ATTEN_LSB = 8;   // Four attenuation selects, 1 = -40 dB
  localparam int CTRL_WIDTH     = 12;

  // Status register field positions
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_PEND_BIT    = 1;
  localparam int STAT_PATTERN_LSB = 16;

  // Path index within the four-bit groups
  localparam int X1_TX1 = 0;
  localparam int X1_TX2 = 1;
  localparam int X2_TX1 = 2;
  localparam int X2_TX2 = 3;

  // Reset values: all paths to receiver, shunts off, -25 dB
  localparam logic [11:0] CTRL_RESET    = 12'h000;
  localparam logic        PEND_RESET    = 1'b1;

  // Serial frame length and pin positions inside each 8-bit register
  localparam int          FRAME_BITS    = 16;
  localparam logic [4:0]  FRAME_LAST    = 5'h0f;
  localparam int          Q0 = 0;
  localparam int          Q1 = 1;
  localparam int          Q2 = 2;
  localparam int          Q3 = 3;
  localparam int          Q4 = 4;
  localparam int          Q5 = 5;
  localparam int          Q6 = 6;
  localparam int          Q7 = 7;

  // Link-side sequencer states
  typedef enum logic [4:0] {
    LS_IDLE  = 5'b00001,
    LS_SETUP = 5'b00010,
    LS_HIGH  = 5'b00100,
    LS_STORE = 5'b01000,
    LS_DONE  = 5'b10000
  } rlb_link_e;

endpackage

//--- rlb_shift_ctrl.sv
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/100ps
module rlb_shift_ctrl #(
  parameter logic [3:0] ATTEN_HIGH_IS_DEEP = 4'hf  // Per path: 1 = high level gives -40 dB
) (
  input  wire logic        core_clk,              // Core clock, 250 MHz
  input  wire logic        rstn,                  // Asynchronous reset, active low
  input  wire logic        linkClk,               // Clock of the shift link
  input  wire logic        psel,                  // APB select
  input  wire logic        penable,               // APB enable
  input  wire logic        pwrite,                // APB direction
  input  wire logic [11:0] paddr,                 // APB byte address
  input  wire logic [31:0] pwdata,                // APB write data
  output logic             pready,                // APB ready
  output logic [31:0]      prdata,                // APB read data
  output logic             pslverr,               // APB error on unmapped address
  output logic             shifterClockOut,       // Shift clock to the chained registers
  output logic             shifterSerialOut,      // Serial data to the first register
  output logic             shifterStoreStrobe     // Latch strobe for both registers
);

  // Build the 16-bit frame from the control fields
  function automatic logic [15:0] mapFrame(input logic [11:0] ctrl);
    logic [3:0] conn;
    logic [3:0] shunt;
    logic [3:0] atten;
    logic [7:0] first;
    logic [7:0] second;
    conn   = ctrl[rlb_pkg::CTRL_CONN_LSB +: 4];
    shunt  = ctrl[rlb_pkg::CTRL_SHUNT_LSB +: 4];
    atten  = ctrl[rlb_pkg::CTRL_ATTEN_LSB +: 4];
    // R11 polarity per attenuation bit
    for (int i = 0; i < 4; i++) begin
      atten[i] = ATTEN_HIGH_IS_DEEP[i] ? atten[i] : ~atten[i];
    end
    first  = 8'h00;
    second = 8'h00;
    // R2 transceiver 1 path 1 route
    first[rlb_pkg::Q5]  = conn[rlb_pkg::X1_TX1];
    first[rlb_pkg::Q4]  = ~conn[rlb_pkg::X1_TX1];
    // R3 transceiver 1 path 2 route
    first[rlb_pkg::Q7]  = conn[rlb_pkg::X1_TX2];
    first[rlb_pkg::Q6]  = ~conn[rlb_pkg::X1_TX2];
    // R4 transceiver 1 shunts
    first[rlb_pkg::Q2]  = shunt[rlb_pkg::X1_TX1];
    first[rlb_pkg::Q0]  = shunt[rlb_pkg::X1_TX2];
    // R5 transceiver 1 attenuation
    first[rlb_pkg::Q3]  = atten[rlb_pkg::X1_TX1];
    first[rlb_pkg::Q1]  = atten[rlb_pkg::X1_TX2];
    // R6 transceiver 2 path 1 route
    second[rlb_pkg::Q2] = conn[rlb_pkg::X2_TX1];
    second[rlb_pkg::Q3] = ~conn[rlb_pkg::X2_TX1];
    // R7 transceiver 2 path 2 route
    second[rlb_pkg::Q0] = conn[rlb_pkg::X2_TX2];
    second[rlb_pkg::Q1] = ~conn[rlb_pkg::X2_TX2];
    // R8 transceiver 2 shunts
    second[rlb_pkg::Q5] = shunt[rlb_pkg::X2_TX1];
    second[rlb_pkg::Q7] = shunt[rlb_pkg::X2_TX2];
    // R9 transceiver 2 attenuation
    second[rlb_pkg::Q6] = atten[rlb_pkg::X2_TX1];
    second[rlb_pkg::Q4] = atten[rlb_pkg::X2_TX2];
    // Far register shifts first, so it sits in the upper byte
    mapFrame = {second, first};
  endfunction

  // ---------------- Core domain ----------------
  logic [11:0] ctrl_q;
  logic        pend_q;
  logic [15:0] frame_q;
  logic        req_q;
  logic        ackMeta_q;
  logic        ackSync_q;
  logic        ackTog_q;               // Driven on the link side
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        busy;
  logic        launch;
  logic        wrCtrl;
  logic        setup;
  logic        access;
  logic        hitCtrl;
  logic        hitStat;

  assign setup   = psel & ~penable;
  assign access  = psel & penable & pready_q;
  assign hitCtrl = (paddr == rlb_pkg::CTRL_OFFSET);
  assign hitStat = (paddr == rlb_pkg::STATUS_OFFSET);
  assign wrCtrl  = access & pwrite & hitCtrl;
  // A frame is in flight while the toggles differ
  assign busy    = (req_q != ackSync_q);
  assign launch  = pend_q & ~busy;

  // Ready one cycle after setup, so answers come from flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~(hitCtrl | hitStat);
      if (setup && !pwrite && hitCtrl) begin
        prdata_q <= {20'h00000, ctrl_q};
      end else if (setup && !pwrite && hitStat) begin
        prdata_q <= {frame_q, 14'h0000, pend_q, busy};
      end else if (setup) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Control register, written in the access cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= rlb_pkg::CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_q <= pwdata[rlb_pkg::CTRL_WIDTH-1:0];
    end
  end

  // Pending update; a new write beats the launch clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= rlb_pkg::PEND_RESET;
    end else if (wrCtrl) begin
      pend_q <= 1'b1;
    end else if (launch) begin
      pend_q <= 1'b0;
    end
  end

  // R1 frame held stable while the link side reads it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      frame_q <= 16'h0000;
      req_q   <= 1'b0;
    end else if (launch) begin
      frame_q <= mapFrame(ctrl_q);
      req_q   <= ~req_q;
    end
  end

  // Acknowledge toggle back from the link domain
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ackMeta_q <= 1'b0;
      ackSync_q <= 1'b0;
    end else begin
      ackMeta_q <= ackTog_q;
      ackSync_q <= ackMeta_q;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ---------------- Link domain ----------------
  logic                  linkRstMeta_q;
  logic                  linkRstn_q;
  logic                  reqMeta_q;
  logic                  reqSync_q;
  logic                  newFrame;
  logic                  lastBit;
  logic [15:0]           shift_q;
  logic [4:0]            count_q;
  rlb_pkg::rlb_link_e    state_q;
  logic                  sclk_q;
  logic                  sdat_q;
  logic                  store_q;

  // Reset release timed to the link clock
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      linkRstMeta_q <= 1'b0;
      linkRstn_q    <= 1'b0;
    end else begin
      linkRstMeta_q <= 1'b1;
      linkRstn_q    <= linkRstMeta_q;
    end
  end

  // Request toggle into the link domain
  always_ff @(posedge linkClk or negedge linkRstn_q) begin
    if (!linkRstn_q) begin
      reqMeta_q <= 1'b0;
      reqSync_q <= 1'b0;
    end else begin
      reqMeta_q <= req_q;
      reqSync_q <= reqMeta_q;
    end
  end

  // A request toggle that differs from the last acknowledge starts a frame
  assign newFrame = (reqSync_q != ackTog_q);
  // Counter end marks the sixteenth bit
  assign lastBit  = (count_q == rlb_pkg::FRAME_LAST);

  // Sequencer state: low phase sets data, high phase clocks it in
  always_ff @(posedge linkClk or negedge linkRstn_q) begin
    if (!linkRstn_q) begin
      state_q <= rlb_pkg::LS_IDLE;
    end else begin
      case (state_q)
        rlb_pkg::LS_IDLE: begin
          if (newFrame) begin
            state_q <= rlb_pkg::LS_SETUP;
          end
        end
        rlb_pkg::LS_SETUP: begin
          state_q <= rlb_pkg::LS_HIGH;
        end
        rlb_pkg::LS_HIGH: begin
          // R10 sixteen bits before latch
          if (lastBit) begin
            state_q <= rlb_pkg::LS_STORE;
          end else begin
            state_q <= rlb_pkg::LS_SETUP;
          end
        end
        rlb_pkg::LS_STORE: begin
          state_q <= rlb_pkg::LS_DONE;
        end
        rlb_pkg::LS_DONE: begin
          state_q <= rlb_pkg::LS_IDLE;
        end
        default: begin
          state_q <= rlb_pkg::LS_IDLE;
        end
      endcase
    end
  end

  // Frame copy; the top bit is the next to leave
  always_ff @(posedge linkClk or negedge linkRstn_q) begin
    if (!linkRstn_q) begin
      shift_q <= 16'h0000;
    end else begin
      case (state_q)
        rlb_pkg::LS_IDLE: begin
          // Safe to copy: the core holds the frame until acknowledged
          if (newFrame) begin
            shift_q <= frame_q;
          end
        end
        rlb_pkg::LS_HIGH: begin
          shift_q <= {shift_q[14:0], 1'b0};
        end
        default: begin
          shift_q <= shift_q;
        end
      endcase
    end
  end

  // Bit counter, cleared at frame start
  always_ff @(posedge linkClk or negedge linkRstn_q) begin
    if (!linkRstn_q) begin
      count_q <= 5'h00;
    end else begin
      case (state_q)
        rlb_pkg::LS_IDLE: begin
          if (newFrame) begin
            count_q <= 5'h00;
          end
        end
        rlb_pkg::LS_HIGH: begin
          if (!lastBit) begin
            count_q <= count_q + 5'h01;
          end
        end
        default: begin
          count_q <= count_q;
        end
      endcase
    end
  end

  // R10 one rising edge per bit
  // Clock rests low outside frames so the chips never see a stray edge
  always_ff @(posedge linkClk or negedge linkRstn_q) begin
    if (!linkRstn_q) begin
      sclk_q <= 1'b0;
    end else begin
      case (state_q)
        rlb_pkg::LS_HIGH: begin
          sclk_q <= 1'b1;
        end
        rlb_pkg::LS_DONE: begin
          sclk_q <= sclk_q;
        end
        default: begin
          sclk_q <= 1'b0;
        end
      endcase
    end
  end

  // R10 most significant bit first
  // Data moves only with the clock low, a full cycle ahead of its rise
  always_ff @(posedge linkClk or negedge linkRstn_q) begin
    if (!linkRstn_q) begin
      sdat_q <= 1'b0;
    end else begin
      case (state_q)
        rlb_pkg::LS_SETUP: begin
          sdat_q <= shift_q[15];
        end
        rlb_pkg::LS_DONE: begin
          sdat_q <= 1'b0;
        end
        default: begin
          sdat_q <= sdat_q;
        end
      endcase
    end
  end

  // R10 single latch pulse after all bits
  always_ff @(posedge linkClk or negedge linkRstn_q) begin
    if (!linkRstn_q) begin
      store_q <= 1'b0;
    end else begin
      case (state_q)
        rlb_pkg::LS_STORE: begin
          store_q <= 1'b1;
        end
        rlb_pkg::LS_SETUP, rlb_pkg::LS_HIGH: begin
          store_q <= store_q;
        end
        default: begin
          store_q <= 1'b0;
        end
      endcase
    end
  end

  // Acknowledge toggle, returned once the latch pulse is over
  always_ff @(posedge linkClk or negedge linkRstn_q) begin
    if (!linkRstn_q) begin
      ackTog_q <= 1'b0;
    end else if (state_q == rlb_pkg::LS_DONE) begin
      ackTog_q <= reqSync_q;
    end
  end

  assign shifterClockOut    = sclk_q;
  assign shifterSerialOut   = sdat_q;
  assign shifterStoreStrobe = store_q;

endmodule

//--- rlb_shift_ctrl_monitor.sv
`timescale 1ns/100ps
module rlb_shift_ctrl_monitor (
  input wire logic        core_clk,           // Core clock
  input wire logic        rstn,               // Reset, active low
  input wire logic        linkClk,            // Link clock
  input wire logic        psel,               // APB select
  input wire logic        penable,            // APB enable
  input wire logic        pwrite,             // APB direction
  input wire logic [11:0] paddr,              // APB address
  input wire logic [31:0] pwdata,             // APB write data
  input wire logic        pready,             // APB ready
  input wire logic [31:0] prdata,             // APB read data
  input wire logic        pslverr,            // APB error
  input wire logic        shifterClockOut,    // Shift clock
  input wire logic        shifterSerialOut,   // Serial data
  input wire logic        shifterStoreStrobe  // Latch strobe
);
  logic       prevClk_q;
  logic [4:0] riseCnt_q;
  // Count shift clock rises per frame; cleared at the strobe
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      prevClk_q <= 1'b0;
      riseCnt_q <= 5'h00;
    end else begin
      prevClk_q <= shifterClockOut;
      if (shifterStoreStrobe) riseCnt_q <= 5'h00;
      else if (shifterClockOut && !prevClk_q) riseCnt_q <= riseCnt_q + 5'h01;
    end
  end
  AST_READY_NEXT: assert property (@(posedge core_clk) disable iff (!rstn) psel && !penable |=> pready)
    else $error("ready missing after setup");
  AST_READY_ONE: assert property (@(posedge core_clk) disable iff (!rstn) pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_QUAL: assert property (@(posedge core_clk) disable iff (!rstn) pslverr |-> pready && psel)
    else $error("error without ready");
  AST_STROBE_ONE: assert property (@(posedge linkClk) disable iff (!rstn)
    shifterStoreStrobe |=> !shifterStoreStrobe)
    else $error("strobe longer than one cycle");
  AST_STROBE_CLK_LOW: assert property (@(posedge linkClk) disable iff (!rstn)
    shifterStoreStrobe |-> !shifterClockOut)
    else $error("strobe while shift clock high");
  AST_DATA_SETUP: assert property (@(posedge linkClk) disable iff (!rstn)
    $rose(shifterClockOut) |-> $stable(shifterSerialOut))
    else $error("data moved with clock rise");
  AST_CLK_PULSE: assert property (@(posedge linkClk) disable iff (!rstn)
    shifterClockOut |=> !shifterClockOut ##1 1'b1)
    else $error("shift clock high too long");
  AST_SIXTEEN: assert property (@(posedge linkClk) disable iff (!rstn)
    shifterStoreStrobe |-> riseCnt_q == 5'h10)
    else $error("strobe not after sixteen bits");
  COV_ERR: cover property (@(posedge core_clk) pslverr);
  COV_WRITE: cover property (@(posedge core_clk) pready && pwrite);
  COV_STROBE: cover property (@(posedge linkClk) shifterStoreStrobe);
endmodule
bind rlb_shift_ctrl rlb_shift_ctrl_monitor u_mon (.core_clk(core_clk), .rstn(rstn), .linkClk(linkClk),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .shifterClockOut(shifterClockOut),
  .shifterSerialOut(shifterSerialOut), .shifterStoreStrobe(shifterStoreStrobe));

//--- rlb_sr_model.sv
`timescale 1ns/100ps
module rlb_sr_model (
  input wire logic       sclk,  // Shift clock
  input wire logic       sdat,  // Serial data into first register
  input wire logic       store, // Latch strobe
  output logic     [7:0] q1,    // First register outputs
  output logic     [7:0] q2     // Second register outputs
);
  logic [15:0] chain;
  // serial chain: first register overflows into second
  always @(posedge sclk) chain <= {chain[14:0], sdat};
  // outputs move together only at the strobe
  always @(posedge store) begin
    q1 <= chain[7:0];
    q2 <= chain[15:8];
  end
endmodule

//--- rlb_shift_ctrl_tb.sv
`timescale 1ns/100ps
module rlb_shift_ctrl_tb;
  localparam logic [3:0] ATT = 4'h5;  // Mixed polarity exercises both senses
  logic        core_clk, rstn, linkClk, psel, penable, pwrite, pready, pslverr, sck, sd, st;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  q1, q2;
  logic        e;
  int          failures, n_checks;
  logic [31:0] d, d2;
  rlb_shift_ctrl #(.ATTEN_HIGH_IS_DEEP(ATT)) uut (.core_clk(core_clk), .rstn(rstn), .linkClk(linkClk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .shifterClockOut(sck), .shifterSerialOut(sd), .shifterStoreStrobe(st));
  rlb_sr_model u_sr (.sclk(sck), .sdat(sd), .store(st), .q1(q1), .q2(q2));
  initial begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    linkClk = 0;
    #3.3;
    forever #7.5 linkClk = ~linkClk;
  end
  task end_sim;
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  // One APB transfer; waits for ready without assuming its latency
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only ready or the watchdog ends this wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll status until no frame is busy or pending
  task settle;
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end while (r[1:0] !== 2'b00 && n < 300);
    if (n >= 300) failures++;
  endtask
  // Pin pattern expected on both registers for a control word
  function automatic logic [15:0] expf(logic [11:0] c);
    logic [3:0] t;
    t = c[11:8] ~^ ATT;
    return {c[7], t[2], c[6], t[3], ~c[2], c[2], ~c[3], c[3], c[1], ~c[1], c[0], ~c[0], t[0], c[4], t[1], c[5]};
  endfunction
  initial begin
    #200000;
    failures++;
    end_sim;
  end
  initial begin
    failures = 0; n_checks = 0;
    rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000; pwdata = 32'h0;
    void'($urandom(32'h917d));
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    settle();
    cmp({16'h0, q2, q1}, {16'h0, expf(12'h000)});
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d2 = $urandom;
      apb(1'b1, 12'h000, d);
      if (i[0]) begin
        apb(1'b1, 12'h000, d2);
        d = d2;
      end
      settle();
      cmp({16'h0, q2, q1}, {16'h0, expf(d[11:0])});
      cmp({r[31:16], 16'h0}, {expf(d[11:0]), 16'h0});
      apb(1'b0, 12'h000, 32'h0);
      cmp(r, {20'h0, d[11:0]});
      cmp({31'h0, e}, 32'h0);
    end
    apb(1'b1, 12'h00c, $urandom);
    cmp({31'h0, e}, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    cmp({r[31:1], e}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    cmp(r, {20'h0, d[11:0]});
    end_sim;
  end
endmodule
